// >>> design/fpes_cycle_timer.sv
// saturating cycle counter used for erase, program and data timeout timing
// assumes clear and run come from logic on sys_clk
`timescale 1ns/100ps
`default_nettype none
module fpes_cycle_timer (
	input  wire logic                     sys_clk,  // system clock
	input  wire logic                     sys_rst,  // synchronous reset, high
	input  wire logic                     clear,    // restart from zero
	input  wire logic                     run,      // count while high
	input  wire logic [fpes_pkg::TMR_W-1:0] limit,  // cycles until done
	output logic                          done      // high on the last counted cycle and after
);
	import fpes_pkg::*;

	fpes_tmr_t r;
	fpes_tmr_t nx;

	always_comb begin
		nx = r;
		if (clear) begin
			nx.cnt = '0;
		end else if (run && (r.cnt != limit - 1'b1)) begin
			nx.cnt = r.cnt + 1'b1;
		end
	end

	// saturates so a late look still sees the expiry
	assign done = run && (r.cnt == limit - 1'b1);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= nx;
		end
	end
endmodule // fpes_cycle_timer
`default_nettype wire

// >>> design/fpes_pkg.sv
// constants, types and state layout for the flash program/erase sequencer
// assumes a single 25 MHz system clock and a flash array with a one-cycle read port
package fpes_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int DATA_TMO_US   = 20;
	localparam int PROG_US       = 20;
	localparam int ERASE_MS      = 20;

	// least times round up
	localparam int DATA_TMO_CYC = (DATA_TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC     = (PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC    = (ERASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W        = 20;

	localparam logic [31:0] REG_CTRL = 32'h0000_0000;
	localparam logic [31:0] REG_ADDR = 32'h0000_0004;
	localparam logic [31:0] REG_DATA = 32'h0000_0008;

	localparam int CTRL_ERASE_BIT = 0;
	localparam int CTRL_PROG_BIT  = 1;
	localparam int CTRL_ABORT_BIT = 5;
	localparam int CTRL_FULL_BIT  = 6;
	localparam int CTRL_BUSY_BIT  = 7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int BIG_PAGE_BYTES   = 2048;
	localparam int SMALL_PAGE_BYTES = 1024;
	localparam int WORD_BYTES       = 4;
	localparam int LOCK_BYTES       = 16;
	localparam int LOCK_WORDS       = LOCK_BYTES / WORD_BYTES;
	localparam int LOCK_BITS_PER_W  = 32;
	localparam logic LOCKED_LEVEL   = 1'b0;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_LOCK_RD  = 7'h02,
		ST_LOCK_CHK = 7'h04,
		ST_ERASE    = 7'h08,
		ST_FILL     = 7'h10,
		ST_MERGE    = 7'h20,
		ST_PROG     = 7'h40
	} fpes_state_t;

	typedef struct packed {
		logic        we;     // one-cycle program strobe
		logic        erase;  // one-cycle page erase strobe
		logic [6:0]  page;   // page to erase
		logic [15:0] waddr;  // word address to program
		logic [31:0] wdata;  // merged word to program
		logic [15:0] raddr;  // word address on the read port
	} fpes_arr_cmd_t;

	typedef struct packed {
		fpes_state_t   st;
		logic          erase;
		logic          prog;
		logic          busy;
		logic          full;
		logic          abort;
		logic          pend;
		logic          trig;
		logic [1:0]    nbytes;
		logic [31:0]   wbuf;
		logic [15:0]   addr;
		fpes_arr_cmd_t arr;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [31:0]   rdata;
	} fpes_regs_t;

	localparam fpes_regs_t FPES_REGS_RST = '{st: ST_IDLE, default: '0};

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
	} fpes_tmr_t;

endpackage

// >>> design/fpes_sequencer.sv
// flash program/erase sequencer with an axi4-lite register slave
// assumes the array returns read data one cycle after raddr and handles
// erase/program strobes itself; all inputs are on sys_clk
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module fpes_sequencer #(
	parameter int       AW           = 12,                    // axi address width
	parameter int       NUM_PAGES    = 128,                   // pages in the array
	parameter bit       SMALL_PAGE   = 1'b0,                  // 1: 1024-byte pages
	parameter int       ERASE_CYCLES = fpes_pkg::ERASE_CYC,   // page erase length
	parameter int       PROG_CYCLES  = fpes_pkg::PROG_CYC,    // word program length
	parameter int       TMO_CYCLES   = fpes_pkg::DATA_TMO_CYC // byte arrival window
) (
	input  wire logic                  sys_clk,          // system clock
	input  wire logic                  sys_rst,          // synchronous reset, high
	input  wire logic [AW-1:0]         s_axi_awaddr,     // write address
	input  wire logic                  s_axi_awvalid,    // write address valid
	output logic                       s_axi_awready,    // write address ready
	input  wire logic [31:0]           s_axi_wdata,      // write data
	input  wire logic [3:0]            s_axi_wstrb,      // write byte enables
	input  wire logic                  s_axi_wvalid,     // write data valid
	output logic                       s_axi_wready,     // write data ready
	output logic [1:0]                 s_axi_bresp,      // write response
	output logic                       s_axi_bvalid,     // write response valid
	input  wire logic                  s_axi_bready,     // write response ready
	input  wire logic [AW-1:0]         s_axi_araddr,     // read address
	input  wire logic                  s_axi_arvalid,    // read address valid
	output logic                       s_axi_arready,    // read address ready
	output logic [31:0]                s_axi_rdata,      // read data
	output logic [1:0]                 s_axi_rresp,      // read response
	output logic                       s_axi_rvalid,     // read data valid
	input  wire logic                  s_axi_rready,     // read data ready
	output fpes_pkg::fpes_arr_cmd_t    arr_cmd,          // commands to the flash array
	input  wire logic [31:0]           arr_rdata,        // array read data, one cycle late
	output logic                       dma_trigger,      // one-cycle dma request pulse
	input  wire logic                  fetch_from_flash, // cpu is fetching from flash
	output logic                       fetch_stall       // hold instruction fetch
);
	import fpes_pkg::*;

	localparam int PAGE_WORDS = (SMALL_PAGE ? SMALL_PAGE_BYTES : BIG_PAGE_BYTES) / WORD_BYTES;
	localparam int LOCK_BASE  = (NUM_PAGES - 1) * PAGE_WORDS + PAGE_WORDS - LOCK_WORDS;

	fpes_regs_t r;
	fpes_regs_t nx;
	logic       wr_fire;
	logic       rd_fire;
	logic       op_run;
	logic       op_done;
	logic       tmo_run;
	logic       tmo_done;
	logic       start_req;
	logic       byte_take;
	logic       page_locked;
	logic [6:0] cur_page;

	function automatic logic is_reg(input logic [AW-1:0] a, input logic [31:0] off);
		is_reg = (a[AW-1:2] == off[AW-1:2]);
	endfunction

	function automatic logic [6:0] page_of(input logic [15:0] a);
		page_of = SMALL_PAGE ? a[14:8] : a[15:9];
	endfunction

	// one lock bit per page, packed into the top words of the last page
	function automatic logic [15:0] lock_word(input logic [6:0] p);
		lock_word = 16'(LOCK_BASE + int'(p) / LOCK_BITS_PER_W);
	endfunction

	assign cur_page    = page_of(r.addr);
	assign page_locked = (arr_rdata[cur_page[4:0]] == LOCKED_LEVEL);
	assign wr_fire     = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
	assign rd_fire     = s_axi_arvalid && !r.rvalid;
	assign start_req   = wr_fire && is_reg(s_axi_awaddr, REG_CTRL) && s_axi_wstrb[0] &&
		!r.busy && (s_axi_wdata[CTRL_ERASE_BIT] || s_axi_wdata[CTRL_PROG_BIT]);
	// a loaded buffer swallows data writes silently
	assign byte_take   = wr_fire && is_reg(s_axi_awaddr, REG_DATA) && s_axi_wstrb[0] &&
		r.prog && !r.full;

	assign op_run  = (r.st == ST_ERASE) || (r.st == ST_PROG);
	assign tmo_run = r.prog && !r.full && ((r.st == ST_FILL) || (r.st == ST_PROG));

	fpes_cycle_timer u_op_timer (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (!op_run),
		.run     (op_run),
		.limit   ((r.st == ST_ERASE) ? TMR_W'(ERASE_CYCLES) : TMR_W'(PROG_CYCLES)),
		.done    (op_done)
	);

	// window restarts whenever the buffer drains
	fpes_cycle_timer u_tmo_timer (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (!tmo_run),
		.run     (tmo_run),
		.limit   (TMR_W'(TMO_CYCLES)),
		.done    (tmo_done)
	);

	always_comb begin
		nx = r;
		nx.arr.we    = 1'b0;
		nx.arr.erase = 1'b0;
		nx.trig      = 1'b0;

		if (r.bvalid && s_axi_bready) begin
			nx.bvalid = 1'b0;
		end
		if (wr_fire) begin
			nx.bvalid = 1'b1;
			nx.bresp  = RESP_OKAY;
			if (is_reg(s_axi_awaddr, REG_CTRL)) begin
				if (start_req) begin
					nx.erase      = s_axi_wdata[CTRL_ERASE_BIT];
					nx.prog       = s_axi_wdata[CTRL_PROG_BIT];
					nx.busy       = 1'b1;
					nx.abort      = 1'b0;
					nx.full       = 1'b0;
					nx.nbytes     = '0;
					nx.st         = ST_LOCK_RD;
					nx.arr.raddr  = lock_word(cur_page);
				end
			end else if (is_reg(s_axi_awaddr, REG_ADDR)) begin
				if (!r.busy && s_axi_wstrb[0]) begin
					nx.addr[7:0] = s_axi_wdata[7:0];
				end
				if (!r.busy && s_axi_wstrb[1]) begin
					nx.addr[15:8] = s_axi_wdata[15:8];
				end
			end else if (is_reg(s_axi_awaddr, REG_DATA)) begin
				if (byte_take) begin
					// low byte arrives first
					nx.wbuf[{r.nbytes, 3'h0} +: 8] = s_axi_wdata[7:0];
					if (r.nbytes == 2'h3) begin
						nx.full   = 1'b1;
						nx.nbytes = '0;
					end else begin
						nx.nbytes = r.nbytes + 2'h1;
						nx.trig   = 1'b1;
					end
				end
			end else begin
				nx.bresp = RESP_SLVERR;
			end
		end

		if (r.rvalid && s_axi_rready) begin
			nx.rvalid = 1'b0;
		end
		if (rd_fire) begin
			nx.rvalid = 1'b1;
			nx.rresp  = RESP_OKAY;
			nx.rdata  = '0;
			if (is_reg(s_axi_araddr, REG_CTRL)) begin
				nx.rdata[CTRL_ERASE_BIT] = r.erase;
				nx.rdata[CTRL_PROG_BIT]  = r.prog;
				nx.rdata[CTRL_ABORT_BIT] = r.abort;
				nx.rdata[CTRL_FULL_BIT]  = r.full;
				nx.rdata[CTRL_BUSY_BIT]  = r.busy;
			end else if (is_reg(s_axi_araddr, REG_ADDR)) begin
				nx.rdata[15:0] = r.addr;
			end else if (!is_reg(s_axi_araddr, REG_DATA)) begin
				nx.rresp = RESP_SLVERR;
			end
		end

		unique case (r.st)
			ST_IDLE: begin
			end
			ST_LOCK_RD: begin
				nx.st = ST_LOCK_CHK;
			end
			ST_LOCK_CHK: begin
				if (page_locked) begin
					nx.abort  = 1'b1;
					nx.erase  = 1'b0;
					nx.prog   = 1'b0;
					nx.busy   = 1'b0;
					nx.full   = 1'b0;
					nx.nbytes = '0;
					nx.st     = ST_IDLE;
				end else if (r.erase) begin
					nx.arr.erase = 1'b1;
					nx.arr.page  = cur_page;
					nx.st        = ST_ERASE;
				end else if (r.full) begin
					nx.arr.raddr = r.addr;
					nx.st        = ST_MERGE;
				end else begin
					nx.trig = 1'b1;
					nx.st   = ST_FILL;
				end
			end
			ST_ERASE: begin
				if (op_done) begin
					nx.erase = 1'b0;
					if (r.prog) begin
						nx.trig = 1'b1;
						nx.st   = ST_FILL;
					end else begin
						nx.busy = 1'b0;
						nx.st   = ST_IDLE;
					end
				end
			end
			ST_FILL: begin
				if (r.full) begin
					// every word rechecks its page, the stream may cross pages
					nx.arr.raddr = lock_word(cur_page);
					nx.st        = ST_LOCK_RD;
				end else if (tmo_done) begin
					nx.prog   = 1'b0;
					nx.busy   = 1'b0;
					nx.full   = 1'b0;
					nx.nbytes = '0;
					nx.st     = ST_IDLE;
				end
			end
			ST_MERGE: begin
				nx.pend = 1'b1;
				nx.st   = ST_PROG;
			end
			ST_PROG: begin
				if (r.pend) begin
					// zeros only ever clear; past the rewrite limits the
					// array content is not guarded here
					nx.arr.wdata = arr_rdata & r.wbuf;
					nx.arr.waddr = r.addr;
					nx.arr.we    = 1'b1;
					nx.pend      = 1'b0;
					nx.full      = 1'b0;
					nx.trig      = 1'b1;
				end
				if (op_done) begin
					nx.addr = r.addr + 16'h0001;
					nx.st   = ST_FILL;
				end
			end
			default: begin
				nx.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= FPES_REGS_RST;
		end else begin
			r <= nx;
		end
	end

	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rresp   = r.rresp;
	assign s_axi_rdata   = r.rdata;
	assign arr_cmd       = r.arr;
	assign dma_trigger   = r.trig;
	assign fetch_stall   = r.busy && fetch_from_flash;

	a_busy_on_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
		start_req |=> r.busy && (r.st == ST_LOCK_RD))
		else $error("busy not raised by a start");

	a_full_after_four: assert property (@(posedge sys_clk) disable iff (sys_rst)
		byte_take && (r.nbytes == 2'h3) && !((r.st == ST_FILL) && tmo_done) |=> r.full)
		else $error("buffer not loaded after fourth byte");

	a_full_ignores_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.full && wr_fire && is_reg(s_axi_awaddr, REG_DATA) |=> $stable(r.wbuf))
		else $error("data write taken while buffer loaded");

	a_abort_clears_op: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(r.abort) |-> !r.busy && !r.prog && !r.erase && $past(r.st == ST_LOCK_CHK))
		else $error("fault flag without a clean stop");

	a_erase_holds_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(r.st == ST_ERASE) |-> r.busy && r.erase)
		else $error("busy or erase low during erase");

	a_erase_before_prog: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.arr.we |-> !r.erase && !$past(r.erase, 2))
		else $error("word programmed before erase done");

	a_merge_and: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.arr.we |-> (r.arr.wdata == ($past(arr_rdata) & r.wbuf)) && (r.arr.waddr == r.addr))
		else $error("programmed word is not the merged value");

	a_timeout_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(r.st == ST_FILL) && !r.full && tmo_done |=> !r.prog && !r.busy && (r.st == ST_IDLE))
		else $error("late data did not end the sequence");

	a_first_trigger: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(r.st == ST_LOCK_CHK) && !page_locked && !r.erase && !r.full |=> dma_trigger ##1 !dma_trigger)
		else $error("no single first trigger after start");

	a_erase_bit_with_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(r.erase) && !r.prog |-> $fell(r.busy))
		else $error("erase bit and busy fell apart");

	a_refill_trigger: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.arr.we |-> dma_trigger && !r.full)
		else $error("drained buffer gave no trigger");

endmodule // fpes_sequencer
`default_nettype wire

// >>> tb/fpes_flash_model.sv
// behavioural flash array standing behind the sequencer's array command port
// assumes strobes and addresses change on sys_clk; unwritten words read as erased
`timescale 1ns/100ps
`default_nettype none
module fpes_flash_model import fpes_pkg::*; #(
	parameter int PAGE_WORDS = 512  // words in one page
) (
	input  wire logic                    sys_clk,   // system clock
	input  wire fpes_pkg::fpes_arr_cmd_t arr_cmd,   // commands from the sequencer
	output logic [31:0]                  arr_rdata  // read data, one cycle late
);
	import fpes_pkg::*;
	// sparse store keeps a full 64k-word array cheap; absent entries are erased words
	logic [31:0] mem [int];
	always @(posedge sys_clk) begin
		// lock words are ordinary words of the last page, read like any other
		arr_rdata <= mem.exists(int'(arr_cmd.raddr)) ? mem[int'(arr_cmd.raddr)] : 32'hffff_ffff;
		if (arr_cmd.we)
			mem[int'(arr_cmd.waddr)] = arr_cmd.wdata;
		if (arr_cmd.erase)
			for (int i = 0; i < PAGE_WORDS; i++)
				mem.delete(int'(arr_cmd.page) * PAGE_WORDS + i);
	end
endmodule // fpes_flash_model
`default_nettype wire

// >>> tb/test_flash_program_erase_sequencer.sv
// self-checking bench for the flash program/erase sequencer
// assumes the flash model as array; the bench plays cpu and dma on the register bus
`timescale 1ns/100ps
`default_nettype none
module test_flash_program_erase_sequencer;
	import fpes_pkg::*;
	localparam int EC = 20;
	logic                  sys_clk, sys_rst, fetch, trig, stall;
	logic [11:0]           awaddr, araddr;
	logic [31:0]           wdata, rdata, ardata, rdat, junk, d2;
	logic                  awvalid, wvalid, bready, arvalid, rready;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, resp;
	fpes_arr_cmd_t         cmd;
	logic [31:0]           d1 [3];
	logic [7:0]            q [$];
	int                    errors, num_checks, seed, trig_seen, used, base, run, span, pg, wa, lk;

	fpes_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(4), .TMO_CYCLES(40)) fpes_sequencer_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.arr_cmd(cmd), .arr_rdata(ardata), .dma_trigger(trig),
		.fetch_from_flash(fetch), .fetch_stall(stall));
	fpes_flash_model fpes_flash_model_inst (.sys_clk(sys_clk), .arr_cmd(cmd), .arr_rdata(ardata));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk; // clock source never changes
	end

	// triggers are one-cycle pulses; count them here so none is lost while a bus cycle runs
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			{trig_seen, base, run, span} <= '0;
		end else begin
			trig_seen <= trig_seen + int'(trig);
			// an accepted control write restarts the per-word count
			if (awvalid && awready && awaddr == REG_CTRL[11:0])
				base <= trig_seen;
			if (cmd.we) begin
				chk("triggers per word", 32'd4, 32'(trig_seen - base));
				base <= trig_seen;
			end
			if (stall)
				run <= run + 1;
			else if (run != 0) begin
				span <= run;
				run <= 0;
			end
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((awready & wready) !== 1'b1 && n < 200);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 200)
			errors++;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (arready !== 1'b1 && n < 200);
		arvalid <= 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		resp = rresp;
		rdat = rdata;
		rready <= 1'b0;
		if (n >= 200)
			errors++;
		@(posedge sys_clk);
	endtask

	task automatic start(input int a, input logic [1:0] m);
		wr(REG_ADDR[11:0], 32'(a));
		used = trig_seen;
		wr(REG_CTRL[11:0], {30'h0, m});
		chk("start write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
	endtask

	// dma stand-in: one byte per trigger, low byte of each word first
	task automatic feed;
		int n;
		foreach (q[i]) begin
			n = 0;
			while (trig_seen == used && n < 300) begin
				@(posedge sys_clk);
				n++;
			end
			if (n >= 300)
				errors++;
			used++;
			wr(REG_DATA[11:0], {24'h0, q[i]});
		end
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			rd(REG_CTRL[11:0]);
			n++;
		end while (rdat[CTRL_BUSY_BIT] !== 1'b0 && n < 200);
	endtask

	function automatic logic [31:0] peek(input int a);
		return fpes_flash_model_inst.mem.exists(a) ? fpes_flash_model_inst.mem[a] : 32'hffff_ffff;
	endfunction

	// zeros written clear bits, ones leave the stored bit alone
	function automatic logic [31:0] prog_result(input logic [31:0] old, input logic [31:0] nw);
		return old & nw;
	endfunction

	task automatic print_verdict;
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		errors++;
		print_verdict;
	end

	initial begin
		{errors, num_checks, used} = '0;
		seed = 18;
		sys_rst = 1'b1;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, fetch} = '0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(REG_CTRL[11:0]);
		chk("ctrl after reset", 32'h0, rdat);
		rd(12'h00c);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmapped read data", 32'h0, rdat);
		wr(12'h010, 32'hffff_ffff);
		chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		// erase and program together over stale contents; 14 bytes leave a partial word
		fetch <= 1'($random(seed));
		pg = ($random(seed) & 32'h7f) % 126;
		wa = pg * 512;
		for (int i = 0; i < 4; i++)
			fpes_flash_model_inst.mem[wa + i] = $random(seed) & 32'h7fff_ffff;
		q = {};
		for (int i = 0; i < 3; i++) begin
			d1[i] = $random(seed);
			for (int b = 0; b < 4; b++)
				q.push_back(d1[i][8*b +: 8]);
		end
		q.push_back(8'h00);
		q.push_back(8'h00);
		start(wa, 2'h3);
		rd(REG_CTRL[11:0]);
		chk("ctrl during erase", 32'h83, rdat);
		feed;
		wait_idle;
		chk("ctrl after timeout", 32'h0, rdat);
		for (int i = 0; i < 3; i++)
			chk("programmed word", d1[i], peek(wa + i));
		chk("partial word", 32'hffff_ffff, peek(wa + 3));
		rd(REG_ADDR[11:0]);
		chk("mapped read resp", {30'h0, RESP_OKAY}, {30'h0, resp});
		chk("addr after three words", 32'(wa + 3), rdat);
		// second program of the same word keeps old zeros
		d2 = $random(seed);
		q = {d2[7:0], d2[15:8], d2[23:16], d2[31:24]};
		start(wa, 2'h2);
		feed;
		// a byte offered while the buffer is loaded must be dropped
		wr(REG_DATA[11:0], {24'h0, ~d2[7:0]});
		wait_idle;
		chk("rewritten word", prog_result(d1[0], d2), peek(wa));
		// each start mode on a locked page aborts and leaves the page alone
		for (int m = 1; m < 4; m++) begin
			pg = ($random(seed) & 32'h7f) % 126;
			lk = 127 * 512 + 508 + pg / 32;
			junk = $random(seed) & 32'hfff0_ffff;
			fpes_flash_model_inst.mem[lk] = ~(32'h1 << (pg % 32));
			fpes_flash_model_inst.mem[pg * 512] = junk;
			start(pg * 512, 2'(m));
			wait_idle;
			chk("ctrl after lock abort", 32'h20, rdat);
			chk("locked page word", junk, peek(pg * 512));
			fpes_flash_model_inst.mem.delete(lk);
		end
		// plain erase with fetch held: stall span shows how long busy stood
		fetch <= 1'b1;
		start(wa, 2'h1);
		// address writes are refused while the erase runs
		wr(REG_ADDR[11:0], ~32'(wa));
		wait_idle;
		chk("ctrl after erase", 32'h0, rdat);
		chk("erase span ok", 32'h1, 32'(span >= EC && span <= EC + 4));
		chk("erased word", 32'hffff_ffff, peek(wa));
		rd(REG_ADDR[11:0]);
		chk("addr kept while busy", 32'(wa), rdat);
		// a second reset once the erase is idle returns the address register to zero
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(REG_ADDR[11:0]);
		chk("addr after reset", 32'h0, rdat);
		fetch <= 1'b0;
		@(posedge sys_clk);
		print_verdict;
	end
endmodule // test_flash_program_erase_sequencer
`default_nettype wire
